// ===== rtl/sf_sched_pkg.sv
/*
  Package for the superframe slot scheduler: register map, field layout,
  reset values, timing constants and enumerations.
  Assumes a symbol clock derived from ref_clk by a fixed cycle count.
*/
package sf_sched_pkg;
  // register indices on the plain register port
  localparam logic [3:0] REG_ORDER   = 4'h0; // beacon/active order, idle rx
  localparam logic [3:0] REG_MODE    = 4'h1; // operating mode, low three bits
  localparam logic [3:0] REG_MARKS   = 4'h2; // slot markers a, b, c
  localparam logic [3:0] REG_NSLOT   = 4'h3; // slot total n, free period start
  localparam logic [3:0] REG_DRIFT   = 4'h4; // signed drift trim per beacon
  localparam logic [3:0] REG_STATUS  = 4'h5; // slot, phase, flags
  localparam logic [3:0] REG_SYMLO   = 4'h6; // symbol counter

  localparam int BCN_LSB  = 0;
  localparam int SO_LSB   = 4;
  localparam int RXI_BIT  = 8;
  localparam int MODE_LSB = 0;
  localparam int BREQ_BIT = 4;
  localparam int MA_LSB   = 0;
  localparam int MB_LSB   = 8;
  localparam int MC_LSB   = 16;
  localparam int N_LSB    = 0;
  localparam int FREE_LSB = 8;

  localparam logic [3:0] ORDER_OFF   = 4'hF;
  localparam logic [3:0] ORDER_MAXBE = 4'hE;
  localparam logic [3:0] BCN_RESET   = 4'hF;
  localparam logic [3:0] SO_RESET    = 4'hF;
  localparam logic [7:0] N_RESET     = 8'h10;

  // base durations in symbols
  localparam int BASE_SLOT_SYMBOLS       = 60;
  localparam int SLOTS_PER_SUPERFRAME    = 16;
  localparam int BASE_SUPERFRAME_SYMBOLS = BASE_SLOT_SYMBOLS * SLOTS_PER_SUPERFRAME;
  localparam int BEACON_SYMBOLS          = 40;
  localparam int SIFS_SYMBOLS            = 12;
  localparam int IFS_SYMBOLS             = 40;
  // one symbol time and its cycle count at 25 MHz
  localparam int SYMBOL_NS     = 200;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CYC_PER_SYM   = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_POINT, MODE_ACCESS, MODE_INFRA_BC, MODE_VEHICLE_BC, MODE_VISIBILITY
  } mode_type;

  typedef enum logic [2:0] {
    SLOT_IDLE, SLOT_BEACON, SLOT_CONTENTION, SLOT_UPLINK, SLOT_DOWNLINK,
    SLOT_DATA, SLOT_VISIBILITY
  } slot_use_type;

  typedef enum logic [1:0] {
    PH_INACTIVE, PH_BEACON, PH_CONTENTION, PH_FREE
  } phase_type;
endpackage : sf_sched_pkg

// ===== rtl/superframe_slot_scheduler.sv
/*
  Superframe slot scheduler: symbol timing, beacon interval, active portion,
  slot counting, virtual-slot mapping per mode, guard gaps, receive accept.
  Assumes a register master on a plain strobe port and a PHY/MAC that reports
  frame reception status and a beacon request command as pulses.
*/
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module superframe_slot_scheduler
  import sf_sched_pkg::*;
#(
  parameter int MAX_ORDER_SHIFT = 14
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  input  wire logic        beaconRequest,
  input  wire logic        phyRxOk,
  input  wire logic        fcsOk,
  input  wire logic        rxDone,
  input  wire logic        cmdPending,
  output logic             beaconStart,
  output logic             slotStart,
  output logic      [7:0]  slotIndex,
  output slot_use_type     slotUse,
  output logic             visibilityTx,
  output logic             guardGap,
  output logic             contentionTxOk,
  output logic             commandTxOk,
  output logic             receiverOn,
  output logic             frameReceived
);
  localparam int SYMW = 32;

  logic rstMeta_ff, rstSync_ff;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end
  wire logic rstN = rstSync_ff;

  // configuration registers
  logic [3:0] beaconOrder_ff, activeOrder_ff;
  logic       rxIdle_ff, beaconReq_ff;
  mode_type   mode_ff;
  logic [7:0] markA_ff, markB_ff, markC_ff, nSlots_ff, freeStart_ff;
  logic [7:0] drift_ff;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      beaconOrder_ff <= BCN_RESET;
      activeOrder_ff <= SO_RESET;
      rxIdle_ff      <= 1'b0;
      mode_ff        <= MODE_POINT;
      markA_ff       <= 8'h00;
      markB_ff       <= 8'h00;
      markC_ff       <= 8'h00;
      nSlots_ff      <= N_RESET;
      freeStart_ff   <= N_RESET;
      drift_ff       <= 8'h00;
    end else if (regWr) begin
      if (regAddr == REG_ORDER) begin
        beaconOrder_ff <= regWrData[BCN_LSB +: 4];
        // active order clamped to beacon order; 15 kept as "off"
        if (regWrData[SO_LSB +: 4] == ORDER_OFF
            || regWrData[SO_LSB +: 4] <= regWrData[BCN_LSB +: 4])
          activeOrder_ff <= regWrData[SO_LSB +: 4];
        else
          activeOrder_ff <= regWrData[BCN_LSB +: 4];
        rxIdle_ff <= regWrData[RXI_BIT];
      end else if (regAddr == REG_MODE) begin
        mode_ff <= mode_type'(regWrData[MODE_LSB +: 3]);
      end else if (regAddr == REG_MARKS) begin
        markA_ff <= regWrData[MA_LSB +: 8];
        markB_ff <= regWrData[MB_LSB +: 8];
        markC_ff <= regWrData[MC_LSB +: 8];
      end else if (regAddr == REG_NSLOT) begin
        nSlots_ff   <= regWrData[N_LSB +: 8];
        freeStart_ff <= regWrData[FREE_LSB +: 8];
      end else if (regAddr == REG_DRIFT) begin
        drift_ff <= regWrData[7:0];
      end
    end
  end

  wire logic beaconEnabled = (beaconOrder_ff <= ORDER_MAXBE);
  // order 15 throws away the active order and any free period
  wire logic noActive = !beaconEnabled || (activeOrder_ff == ORDER_OFF);
  wire logic [3:0] soEff = noActive ? 4'h0 : activeOrder_ff;

  // symbol prescaler
  logic [3:0] preCnt_ff;
  wire logic symTick = (preCnt_ff == 4'(CYC_PER_SYM - 1));
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) preCnt_ff <= 4'h0;
    else preCnt_ff <= symTick ? 4'h0 : preCnt_ff + 4'h1;
  end

  // interval, active length and slot length in symbols
  wire logic [SYMW-1:0] intervalSyms =
    SYMW'(BASE_SUPERFRAME_SYMBOLS) << beaconOrder_ff;
  wire logic [SYMW-1:0] activeSyms = noActive ? SYMW'(BEACON_SYMBOLS)
    : SYMW'(BASE_SUPERFRAME_SYMBOLS) << soEff;
  wire logic [SYMW-1:0] slotSyms = SYMW'(BASE_SLOT_SYMBOLS) << soEff;
  wire logic [SYMW-1:0] trimmedInterval =
    intervalSyms + SYMW'(signed'(drift_ff));

  logic [SYMW-1:0] symCnt_ff, slotSym_ff;
  logic [7:0]      slot_ff;
  logic            running_ff, pendBeacon_ff;
  phase_type       phase_ff;

  // one-shot beacon request when beacons are off
  wire logic reqBeacon = !beaconEnabled && (beaconRequest || pendBeacon_ff);
  // a shorter interval written mid-period ends it at once, no wraparound wait
  wire logic periodEnd = beaconEnabled && running_ff && symTick
                         && (symCnt_ff >= trimmedInterval - SYMW'(1));
  wire logic startBeacon = symTick && (periodEnd
    || (beaconEnabled && !running_ff) || reqBeacon);
  wire logic activeEnd = symTick && (symCnt_ff == activeSyms - SYMW'(1));
  // the last boundary of the active portion opens no slot
  wire logic slotEnd = symTick && phase_ff != PH_INACTIVE && !activeEnd
                       && (slotSym_ff == slotSyms - SYMW'(1));

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) pendBeacon_ff <= 1'b0;
    else if (startBeacon) pendBeacon_ff <= 1'b0;
    else if (beaconRequest && !beaconEnabled) pendBeacon_ff <= 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      symCnt_ff  <= '0;
      slotSym_ff <= '0;
      slot_ff    <= 8'h00;
      running_ff <= 1'b0;
      phase_ff   <= PH_INACTIVE;
    end else if (startBeacon) begin
      symCnt_ff  <= '0;
      slotSym_ff <= '0;
      slot_ff    <= 8'h00;
      running_ff <= beaconEnabled;
      phase_ff   <= PH_BEACON;
    end else if (symTick) begin
      symCnt_ff <= symCnt_ff + SYMW'(1);
      if (activeEnd) begin
        phase_ff <= PH_INACTIVE;
      end else if (phase_ff == PH_BEACON
                   && symCnt_ff == SYMW'(BEACON_SYMBOLS - 1)) begin
        phase_ff <= PH_CONTENTION;
      end
      if (slotEnd) begin
        slotSym_ff <= '0;
        slot_ff    <= slot_ff + 8'h01;
        if (phase_ff == PH_CONTENTION && slot_ff + 8'h01 >= freeStart_ff)
          phase_ff <= PH_FREE;
      end else if (phase_ff != PH_INACTIVE) begin
        slotSym_ff <= slotSym_ff + SYMW'(1);
      end
    end
  end

  // virtual slot mapping, slot numbers 1..n against markers
  slot_use_type nxt_use;
  wire logic [7:0] vs = slot_ff + 8'h01;
  always_comb begin
    nxt_use = SLOT_IDLE;
    if (phase_ff == PH_INACTIVE || vs > nSlots_ff) begin
      nxt_use = SLOT_IDLE;
    end else begin
      case (mode_ff)
        MODE_POINT: nxt_use = SLOT_DATA;
        MODE_ACCESS: begin
          if (vs <= markA_ff) nxt_use = SLOT_BEACON;
          else if (vs <= markB_ff) nxt_use = SLOT_CONTENTION;
          else if (vs <= markC_ff) nxt_use = SLOT_UPLINK;
          else nxt_use = SLOT_DOWNLINK;
        end
        MODE_INFRA_BC, MODE_VEHICLE_BC:
          nxt_use = (vs <= markA_ff) ? SLOT_BEACON : SLOT_DOWNLINK;
        default: nxt_use = SLOT_VISIBILITY;
      endcase
      // links kept out of the contention period, contention kept out of the free period
      if (phase_ff == PH_CONTENTION
          && (nxt_use == SLOT_UPLINK || nxt_use == SLOT_DOWNLINK))
        nxt_use = SLOT_CONTENTION;
      if (phase_ff == PH_FREE && nxt_use == SLOT_CONTENTION)
        nxt_use = SLOT_IDLE;
    end
    if (!beaconEnabled && (nxt_use == SLOT_UPLINK || nxt_use == SLOT_DOWNLINK))
      nxt_use = SLOT_IDLE;
  end

  slot_use_type prevUse_ff;
  logic [7:0]   guardCnt_ff;
  logic         slotStartNow;
  assign slotStartNow = startBeacon || slotEnd;
  // slot use turns a cycle after the boundary, so every cycle is watched
  wire logic dirFlip = prevUse_ff != nxt_use
    && ((prevUse_ff == SLOT_UPLINK && nxt_use == SLOT_DOWNLINK)
     || (prevUse_ff == SLOT_DOWNLINK && nxt_use == SLOT_UPLINK));

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      guardCnt_ff <= 8'h00;
      prevUse_ff  <= SLOT_IDLE;
    end else begin
      prevUse_ff <= nxt_use;
      if (dirFlip) guardCnt_ff <= 8'(SIFS_SYMBOLS);
      else if (symTick && guardCnt_ff != 8'h00) guardCnt_ff <= guardCnt_ff - 8'h01;
    end
  end

  // contention tx allowed only if a slot-plus-ack fits before ifs
  wire logic [SYMW-1:0] contEnd = slotSyms * SYMW'(freeStart_ff);
  wire logic contTxFits = phase_ff == PH_CONTENTION
    && symCnt_ff + slotSyms + SYMW'(IFS_SYMBOLS) <= contEnd;

  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      beaconStart    <= 1'b0;
      slotStart      <= 1'b0;
      slotIndex      <= 8'h00;
      slotUse        <= SLOT_IDLE;
      visibilityTx   <= 1'b0;
      guardGap       <= 1'b0;
      contentionTxOk <= 1'b0;
      commandTxOk    <= 1'b0;
      receiverOn     <= 1'b0;
      frameReceived  <= 1'b0;
    end else begin
      beaconStart    <= startBeacon;
      // a slot start lets the phy open with the preamble, parts in fixed order
      slotStart      <= slotStartNow;
      slotIndex      <= startBeacon ? 8'h00 : (slotEnd ? slot_ff + 8'h01 : slot_ff);
      slotUse        <= nxt_use;
      // idle, contention and uplink slots keep the light on; visibility
      // frames carry headers plus pattern, the phy builds the frame body
      visibilityTx   <= nxt_use == SLOT_IDLE || nxt_use == SLOT_CONTENTION
        || nxt_use == SLOT_UPLINK || nxt_use == SLOT_VISIBILITY;
      guardGap       <= dirFlip || guardCnt_ff > 8'h01;
      contentionTxOk <= contTxFits;
      commandTxOk    <= contTxFits && cmdPending;
      receiverOn     <= beaconEnabled ? phase_ff != PH_INACTIVE
                        : rxIdle_ff;
      frameReceived  <= rxDone && phyRxOk && fcsOk;
    end
  end

  // register read, data in the following cycle
  logic [31:0] nxt_rd;
  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (regAddr == REG_ORDER)
      nxt_rd = {23'h0, rxIdle_ff, activeOrder_ff, beaconOrder_ff};
    else if (regAddr == REG_MODE)
      nxt_rd = {29'h0, mode_ff};
    else if (regAddr == REG_MARKS)
      nxt_rd = {8'h00, markC_ff, markB_ff, markA_ff};
    else if (regAddr == REG_NSLOT)
      nxt_rd = {16'h0, freeStart_ff, nSlots_ff};
    else if (regAddr == REG_DRIFT)
      nxt_rd = {24'h0, drift_ff};
    else if (regAddr == REG_STATUS)
      nxt_rd = {16'h0, 3'h0, beaconEnabled, 1'b0, nxt_use, phase_ff, 1'b0,
                running_ff, slot_ff[3:0]};
    else if (regAddr == REG_SYMLO)
      nxt_rd = symCnt_ff;
  end
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) regRdData <= 32'h0000_0000;
    else regRdData <= regRd ? nxt_rd : 32'h0000_0000;
  end

  // checks
  property p_beacon_off_no_auto;
    @(posedge ref_clk) disable iff (!rstN)
    (!beaconEnabled && !beaconRequest && !pendBeacon_ff) |=> !beaconStart;
  endproperty
  a_beacon_off_no_auto: assert property (p_beacon_off_no_auto)
    else $error("beacon sent without request while beacons off");
  property p_slot0_at_beacon;
    @(posedge ref_clk) disable iff (!rstN)
    startBeacon |=> (slot_ff == 8'h00 && symCnt_ff == '0 && phase_ff == PH_BEACON);
  endproperty
  a_slot0_at_beacon: assert property (p_slot0_at_beacon)
    else $error("beacon did not restart slot 0");
  property p_rx_idle;
    @(posedge ref_clk) disable iff (!rstN)
    !beaconEnabled ##1 !beaconEnabled |-> receiverOn == $past(rxIdle_ff);
  endproperty
  a_rx_idle: assert property (p_rx_idle)
    else $error("receiver enable not following idle setting");
  property p_receipt;
    @(posedge ref_clk) disable iff (!rstN)
    frameReceived |-> $past(phyRxOk) && $past(fcsOk) && $past(rxDone);
  endproperty
  a_receipt: assert property (p_receipt)
    else $error("frame accepted without phy and check ok");
  property p_cmd_in_cont;
    @(posedge ref_clk) disable iff (!rstN)
    commandTxOk |-> $past(phase_ff) == PH_CONTENTION;
  endproperty
  a_cmd_in_cont: assert property (p_cmd_in_cont)
    else $error("command allowed outside contention");
  property p_point_data;
    @(posedge ref_clk) disable iff (!rstN)
    (mode_ff == MODE_POINT && phase_ff == PH_BEACON && vs <= nSlots_ff) |->
      nxt_use == SLOT_DATA;
  endproperty
  a_point_data: assert property (p_point_data)
    else $error("point-to-point slot not data");
  property p_free_no_contention;
    @(posedge ref_clk) disable iff (!rstN)
    phase_ff == PH_FREE |=> slotUse != SLOT_CONTENTION;
  endproperty
  a_free_no_contention: assert property (p_free_no_contention)
    else $error("contention slot in free period");
  property p_guard;
    @(posedge ref_clk) disable iff (!rstN)
    dirFlip |=> guardGap;
  endproperty
  a_guard: assert property (p_guard)
    else $error("no guard on direction change");
  property p_so_clamp;
    @(posedge ref_clk) disable iff (!rstN)
    activeOrder_ff == ORDER_OFF || activeOrder_ff <= beaconOrder_ff;
  endproperty
  a_so_clamp: assert property (p_so_clamp)
    else $error("active order above beacon order");

  c_beacon: cover property (@(posedge ref_clk) disable iff (!rstN) beaconStart);
  c_free: cover property (@(posedge ref_clk) disable iff (!rstN) phase_ff == PH_FREE);
  c_guard: cover property (@(posedge ref_clk) disable iff (!rstN) guardGap);
  c_rx: cover property (@(posedge ref_clk) disable iff (!rstN) frameReceived);
endmodule : superframe_slot_scheduler

// ===== test/sched_peer_model.sv
/*
  Peer device model: presents the reception status of one frame from the far
  side, promptly or after a lag, as three levels sampled together.
  Assumes the bench pulses frameGo for one cycle with the wanted outcome.
*/
`timescale 1ns/1ps
module sched_peer_model (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       frameGo,
  input  wire logic [3:0] lagCyc,
  input  wire logic       phyGood,
  input  wire logic       fcsGood,
  output logic            phyRxOk,
  output logic            fcsOk,
  output logic            rxDone
);
  logic [4:0] lagCnt_ff;
  logic       goodPhy_ff;
  logic       goodFcs_ff;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lagCnt_ff  <= 5'h00;
      goodPhy_ff <= 1'b0;
      goodFcs_ff <= 1'b0;
    end else if (frameGo) begin
      lagCnt_ff  <= {1'b0, lagCyc} + 5'h01;
      goodPhy_ff <= phyGood;
      goodFcs_ff <= fcsGood;
    end else if (lagCnt_ff != 5'h00) begin
      lagCnt_ff <= lagCnt_ff - 5'h01;
    end
  end

  // status lines wander outside the done cycle so stale values cannot pass
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxDone  <= 1'b0;
      phyRxOk <= 1'b0;
      fcsOk   <= 1'b1;
    end else if (lagCnt_ff == 5'h01) begin
      rxDone  <= 1'b1;
      phyRxOk <= goodPhy_ff;
      fcsOk   <= goodFcs_ff;
    end else begin
      rxDone  <= 1'b0;
      phyRxOk <= ~phyRxOk;
      fcsOk   <= phyRxOk;
    end
  end
endmodule : sched_peer_model

// ===== test/superframe_slot_scheduler_tb_top.sv
/*
  Testbench for the superframe slot scheduler: registers, beacon timing,
  slot mapping per mode, link flags and frame acceptance.
  Assumes sf_sched_pkg and the peer model sched_peer_model.
*/
`timescale 1ns/1ps
module superframe_slot_scheduler_tb_top
  import sf_sched_pkg::*;
;
  logic         ref_clk, nrst, regWr, regRd, beaconRequest, cmdPending;
  logic [3:0]   regAddr, lagCyc;
  logic [31:0]  regWrData, regRdData;
  logic         phyRxOk, fcsOk, rxDone, frameGo, phyGood, fcsGood;
  logic         beaconStart, slotStart, visibilityTx, guardGap;
  logic         contentionTxOk, commandTxOk, receiverOn, frameReceived;
  logic [7:0]   slotIndex;
  slot_use_type slotUse;
  int           n_fail = 0;
  int           comparisons = 0;

  superframe_slot_scheduler superframe_slot_scheduler_i (
    .ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .beaconRequest(beaconRequest), .phyRxOk(phyRxOk), .fcsOk(fcsOk),
    .rxDone(rxDone), .cmdPending(cmdPending), .beaconStart(beaconStart),
    .slotStart(slotStart), .slotIndex(slotIndex), .slotUse(slotUse),
    .visibilityTx(visibilityTx), .guardGap(guardGap),
    .contentionTxOk(contentionTxOk), .commandTxOk(commandTxOk),
    .receiverOn(receiverOn), .frameReceived(frameReceived)
  );

  sched_peer_model sched_peer_model_i (
    .ref_clk(ref_clk), .nrst(nrst), .frameGo(frameGo), .lagCyc(lagCyc),
    .phyGood(phyGood), .fcsGood(fcsGood), .phyRxOk(phyRxOk), .fcsOk(fcsOk),
    .rxDone(rxDone)
  );

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check32

  task automatic check_bit(input logic got, input logic exp);
    check32({31'h0, got}, {31'h0, exp});
  endtask : check_bit

  task automatic check_use(input slot_use_type got, input slot_use_type exp);
    check32({29'h0, got}, {29'h0, exp});
  endtask : check_use

  // every wait_hi wait is bounded; running out ends the run as a failure
  task automatic wait_hi(ref logic sig, input int lim);
    int k;
    k = 0;
    do begin
      @(posedge ref_clk);
      #1;
      k++;
    end while (sig !== 1'b1 && k < lim);
    if (sig !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: timeout got %0h expected 1", $time, sig);
      stop_test();
    end
  endtask : wait_hi

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : reg_read

  task automatic count_pulses(input int len, output int nb, output int ns);
    nb = 0;
    ns = 0;
    repeat (len) begin
      @(posedge ref_clk);
      #1;
      if (beaconStart === 1'b1) nb++;
      if (slotStart === 1'b1) ns++;
    end
  endtask : count_pulses

  task automatic test_reset();
    logic [31:0] d;
    int nb, ns;
    reg_read(REG_ORDER, d);
    check32(d, 32'h000000FF);
    reg_read(REG_NSLOT, d);
    check32(d, 32'h00001010);
    reg_write(4'hF, 32'hFFFFFFFF);
    reg_read(4'hF, d);
    check32(d, 32'h00000000);
    count_pulses(6000, nb, ns);
    check32(nb, 0);
    check32(ns, 0);
    $display("test reset done");
  endtask : test_reset

  task automatic test_request();
    int nb, ns;
    reg_write(REG_ORDER, 32'h0000010F);
    repeat (8) @(posedge ref_clk);
    #1;
    check_bit(receiverOn, 1'b1);
    @(posedge ref_clk);
    beaconRequest <= 1'b1;
    @(posedge ref_clk);
    beaconRequest <= 1'b0;
    // the beacon may already start at the request edge
    #1;
    if (beaconStart !== 1'b1) wait_hi(beaconStart, 20);
    check_bit(slotStart, 1'b1);
    count_pulses(1000, nb, ns);
    check32(nb, 0);
    check32(ns, 0);
    reg_write(REG_ORDER, 32'h0000000F);
    repeat (8) @(posedge ref_clk);
    #1;
    check_bit(receiverOn, 1'b0);
    $display("test request done");
  endtask : test_request

  task automatic test_receive();
    logic [3:0] okP, okF;
    int np;
    okP = 4'b1011;
    okF = 4'b1101;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      frameGo <= 1'b1;
      phyGood <= okP[k];
      fcsGood <= okF[k];
      lagCyc  <= 4'(k * 3);
      @(posedge ref_clk);
      frameGo <= 1'b0;
      np = 0;
      repeat (16) begin
        @(posedge ref_clk);
        #1;
        if (frameReceived === 1'b1) np++;
      end
      check32(np, {31'h0, okP[k] & okF[k]});
    end
    $display("test receive done");
  endtask : test_receive

  task automatic test_interval(input logic [3:0] bo, so, input int drift);
    logic [31:0] d;
    logic [3:0]  se;
    int cyc, ns, first;
    se = (so > bo) ? bo : so;
    reg_write(REG_DRIFT, 32'(drift) & 32'h000000FF);
    reg_write(REG_ORDER, {24'h0, so, bo});
    reg_read(REG_ORDER, d);
    check32(d, {24'h0, se, bo});
    // the first beacon may still follow the old settings
    wait_hi(beaconStart, 30000);
    wait_hi(beaconStart, 30000);
    check32({24'h0, slotIndex}, 32'h0);
    cyc = 0;
    ns = 0;
    first = 0;
    do begin
      @(posedge ref_clk);
      #1;
      cyc++;
      if (slotStart === 1'b1 && beaconStart !== 1'b1) ns++;
      if (ns == 1 && first == 0) first = cyc;
    end while (beaconStart !== 1'b1 && cyc < 30000);
    check32(cyc, ((BASE_SUPERFRAME_SYMBOLS << bo) + drift) * CYC_PER_SYM);
    check32(ns, SLOTS_PER_SUPERFRAME - 1);
    check32(first, (BASE_SLOT_SYMBOLS << se) * CYC_PER_SYM);
    $display("test interval done");
  endtask : test_interval

  function automatic slot_use_type exp_use(mode_type m, logic [7:0] vs, a, b, c);
    if (m == MODE_POINT) return SLOT_DATA;
    if (m == MODE_VISIBILITY) return SLOT_VISIBILITY;
    if (vs <= a) return SLOT_BEACON;
    if (m != MODE_ACCESS) return SLOT_DOWNLINK;
    if (vs <= b) return SLOT_CONTENTION;
    if (vs <= c) return SLOT_UPLINK;
    return SLOT_DOWNLINK;
  endfunction : exp_use

  task automatic run_frame(input mode_type m, input logic [7:0] a, b, c);
    logic [7:0] vs;
    reg_write(REG_MODE, {29'h0, m});
    reg_write(REG_MARKS, {8'h00, c, b, a});
    reg_write(REG_NSLOT, {16'h0, b, 8'h10});
    wait_hi(beaconStart, 6000);
    for (int i = 1; i < SLOTS_PER_SUPERFRAME; i++) begin
      cmdPending <= i[0];
      wait_hi(slotStart, 400);
      repeat (2) @(posedge ref_clk);
      #1;
      vs = slotIndex + 8'h01;
      check32({24'h0, slotIndex}, 32'(i));
      check_use(slotUse, exp_use(m, vs, a, b, c));
      if (m == MODE_VISIBILITY) check_bit(visibilityTx, 1'b1);
      if (m == MODE_ACCESS) begin
        check_bit(contentionTxOk, vs < b);
        check_bit(commandTxOk, vs < b && i[0]);
        if (vs > a && vs <= c) check_bit(visibilityTx, 1'b1);
        if (vs > b && vs <= c + 8'h01) check_bit(guardGap, vs == c + 8'h01);
      end
    end
    cmdPending <= 1'b0;
    $display("test frame mode %0d done", m);
  endtask : run_frame

  initial begin
    nrst = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    beaconRequest = 1'b0;
    cmdPending = 1'b0;
    frameGo = 1'b0;
    lagCyc = 4'h0;
    phyGood = 1'b0;
    fcsGood = 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_reset();
    test_request();
    test_receive();
    test_interval(4'h1, 4'h0, -4);
    test_interval(4'h0, 4'h1, 0);
    run_frame(MODE_ACCESS, 8'h01, 8'h04, 8'h0A);
    run_frame(MODE_INFRA_BC, 8'h02, 8'h02, 8'h02);
    run_frame(MODE_VEHICLE_BC, 8'h00, 8'h00, 8'h00);
    run_frame(MODE_POINT, 8'h00, 8'h00, 8'h00);
    run_frame(MODE_VISIBILITY, 8'h00, 8'h00, 8'h00);
    stop_test();
  end
endmodule : superframe_slot_scheduler_tb_top
